/* File: rtl/dpll_mode_pkg.sv */
// Constants, types and register map for the loop mode controller.
// What this block does
// - After any reset the loop runs free until it has once been synchronized.
// - A qualified reference starts lock acquisition on that reference.
// - Successful acquisition on a stable reference enters normal, locked operation.
// - Losing the reference in normal with no other qualified one enters holdover.
// - Holdover starts from averaged history so the initial offset stays small.
// - The mode pin is caught on the first enabled edge after reset and shown in the mode register.
// - An unconnected mode pin, pulled high, gives manual free-run.
// - Pin low gives manual normal: fixed reference from register, holdover on failure.
// - Pin high gives manual free-run with no automatic reference switching.
// - Software sets the mode unless the pin-control bit hands it to the pin.
// - A bandwidth field chooses 0.1 Hz, 14 Hz, 28 Hz or wideband.
// - Wideband means 890 Hz above 8 kHz, 56 Hz at 8 kHz, 14 Hz at 2 kHz.
// - For 2 kHz references only 0.1 Hz or 14 Hz bandwidth is used.
// - Phase slope limit is 885 ns/s, 7.5 us/s, 61 us/s or unlimited.
// - The interrupt output goes active on any change of reported status.
// - Lock and holdover status are driven on their own output pins.
// - Hitless reference switching can be turned on or off by software.
// - Reference choice is automatic by priority and revertive setting, or manual.
package dpll_mode_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [6:0] hardware_pin_control_addr = 7'h01;
	localparam logic [6:0] device_status_addr = 7'h02;
	localparam logic [6:0] loop_control_primary_addr = 7'h1d;
	localparam logic [6:0] loop_control_secondary_addr = 7'h1e;
	localparam logic [6:0] operating_mode_select_addr = 7'h1f;
	localparam logic [6:0] manual_reference_select_addr = 7'h20;
	localparam logic [6:0] reference_priority_low_addr = 7'h24;
	localparam logic [6:0] reference_priority_high_addr = 7'h25;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int pin_control_bit = 0;
	localparam int bandwidth_lsb = 0;
	localparam int slope_limit_lsb = 2;
	localparam int hitless_bit = 4;
	localparam int revertive_bit = 0;
	localparam logic [7:0] loop_control_primary_reset = 8'h10;
	localparam logic [7:0] loop_control_secondary_reset = 8'h01;
	localparam logic [7:0] manual_reference_select_reset = 8'h00;
	localparam logic [7:0] reference_priority_low_reset = 8'h10;
	localparam logic [7:0] reference_priority_high_reset = 8'h02;
	localparam logic [3:0] priority_never = 4'hf;
	localparam int history_shift = 4;
	localparam int ref_count = 3;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		mode_manual_normal = 2'b00,
		mode_manual_free_run = 2'b01,
		mode_auto_normal = 2'b10
	} op_mode_t;

	typedef enum logic [1:0] {
		st_free_run = 2'b00,
		st_acquiring = 2'b01,
		st_normal = 2'b10,
		st_holdover = 2'b11
	} dpll_state_t;

	typedef enum logic [1:0] {
		bw_sel_0p1 = 2'b00,
		bw_sel_14 = 2'b01,
		bw_sel_28 = 2'b10,
		bw_sel_wide = 2'b11
	} bw_sel_t;

	typedef enum logic [2:0] {
		bw_0p1_hz = 3'b000,
		bw_14_hz = 3'b001,
		bw_28_hz = 3'b010,
		bw_56_hz = 3'b011,
		bw_890_hz = 3'b100
	} bw_eff_t;

	typedef enum logic [1:0] {
		psl_885_ns = 2'b00,
		psl_7p5_us = 2'b01,
		psl_61_us = 2'b10,
		psl_unlimited = 2'b11
	} phase_slope_limit_t;

	typedef struct packed {
		bw_eff_t bandwidth;
		phase_slope_limit_t phase_slope_limit;
		logic hitless;
	} loop_cfg_t;

	typedef struct packed {
		logic ever_synced;
		logic [1:0] active_ref;
		dpll_state_t state;
	} status_t;

endpackage

/* File: rtl/dpll_mode_controller.sv */
// Mode, reference and loop setting control for the network timing loop.
`timescale 1ns/1ps
module dpll_mode_controller (
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable,
	input wire logic mode_pin,
	input wire logic [2:0] ref_qualified,
	input wire logic [2:0] ref_is_2k,
	input wire logic [2:0] ref_is_8k,
	input wire logic acquisition_done,
	input wire logic [23:0] loop_freq,
	input wire logic [6:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output dpll_mode_pkg::status_t status,
	output dpll_mode_pkg::loop_cfg_t loop_cfg,
	output logic [23:0] holdover_freq,
	output logic lock_pin,
	output logic holdover_pin,
	output logic irq_n
);
	import dpll_mode_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] hardware_pin_control;
	logic [7:0] loop_control_primary;
	logic [7:0] loop_control_secondary;
	logic [7:0] operating_mode_select;
	logic [7:0] manual_reference_select;
	logic [7:0] reference_priority_low;
	logic [7:0] reference_priority_high;
	logic strap_taken;
	logic status_pending;

	logic wr_en;
	assign wr_en = clock_enable && reg_write;

	// The strap is caught on the first enabled edge after release, never by the reset itself.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strap_taken <= 1'b0;
		end else if (clock_enable) begin
			strap_taken <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			operating_mode_select <= 8'h00;
		end else if (clock_enable) begin
			if (!strap_taken) begin
				// A floating pin reads high through its pull-up, giving manual free-run.
				operating_mode_select <= mode_pin ? 8'h01 : 8'h00;
			end else if (reg_write && reg_addr == operating_mode_select_addr) begin
				operating_mode_select <= {6'h00, reg_wdata[1:0]};
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hardware_pin_control <= 8'h00;
			loop_control_primary <= loop_control_primary_reset;
			loop_control_secondary <= loop_control_secondary_reset;
			manual_reference_select <= manual_reference_select_reset;
			reference_priority_low <= reference_priority_low_reset;
			reference_priority_high <= reference_priority_high_reset;
		end else if (wr_en) begin
			unique case (reg_addr)
				hardware_pin_control_addr: hardware_pin_control <= {7'h00, reg_wdata[0]};
				loop_control_primary_addr: loop_control_primary <= {3'h0, reg_wdata[4:0]};
				loop_control_secondary_addr: loop_control_secondary <= {7'h00, reg_wdata[0]};
				manual_reference_select_addr: manual_reference_select <= {6'h00, reg_wdata[1:0]};
				reference_priority_low_addr: reference_priority_low <= reg_wdata;
				reference_priority_high_addr: reference_priority_high <= {4'h0, reg_wdata[3:0]};
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Mode source
	// ****************************************
	op_mode_t mode;
	always_comb begin
		if (hardware_pin_control[pin_control_bit]) begin
			mode = mode_pin ? mode_manual_free_run : mode_manual_normal;
		end else begin
			unique case (operating_mode_select[1:0])
				2'b00: mode = mode_manual_normal;
				2'b10: mode = mode_auto_normal;
				default: mode = mode_manual_free_run;
			endcase
		end
	end

	// ****************************************
	// Reference choice
	// ****************************************
	dpll_state_t state;
	logic [1:0] active_ref;
	logic ever_synced;
	logic [3:0] prio [ref_count];
	logic [1:0] best_ref;
	logic best_found;
	logic [1:0] next_ref;
	logic next_valid;

	assign prio[0] = reference_priority_low[3:0];
	assign prio[1] = reference_priority_low[7:4];
	assign prio[2] = reference_priority_high[3:0];

	// Strict less-than keeps the lowest-numbered reference on equal priority.
	always_comb begin
		best_ref = 2'd0;
		best_found = 1'b0;
		for (int i = 0; i < ref_count; i++) begin
			if (ref_qualified[i] && prio[i] != priority_never &&
				(!best_found || prio[i] < prio[best_ref])) begin
				best_ref = 2'(i);
				best_found = 1'b1;
			end
		end
	end

	always_comb begin
		if (mode == mode_manual_normal) begin
			next_ref = manual_reference_select[1:0];
			next_valid = manual_reference_select[1:0] != 2'd3 &&
				ref_qualified[manual_reference_select[1:0]];
		end else if (mode == mode_auto_normal) begin
			if (!loop_control_secondary[revertive_bit] && state != st_free_run &&
				active_ref != 2'd3 && ref_qualified[active_ref]) begin
				next_ref = active_ref;
			end else begin
				next_ref = best_ref;
			end
			next_valid = (next_ref == active_ref && state != st_free_run &&
				active_ref != 2'd3 && ref_qualified[active_ref]) || best_found;
		end else begin
			next_ref = active_ref;
			next_valid = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_ref <= 2'd0;
		end else if (clock_enable && next_valid) begin
			active_ref <= next_ref;
		end
	end

	// ****************************************
	// Operating state
	// ****************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= st_free_run;
		end else if (clock_enable) begin
			if (!strap_taken || mode == mode_manual_free_run) begin
				state <= st_free_run;
			end else begin
				unique case (state)
					st_free_run: begin
						if (next_valid) begin
							state <= st_acquiring;
						end
					end
					st_acquiring: begin
						if (!next_valid) begin
							state <= ever_synced ? st_holdover : st_free_run;
						end else if (acquisition_done) begin
							state <= st_normal;
						end
					end
					st_normal: begin
						if (!next_valid) begin
							state <= st_holdover;
						end else if (next_ref != active_ref) begin
							state <= st_acquiring;
						end
					end
					st_holdover: begin
						if (next_valid) begin
							state <= st_acquiring;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ever_synced <= 1'b0;
		end else if (clock_enable && state == st_normal) begin
			ever_synced <= 1'b1;
		end
	end

	// ****************************************
	// Holdover history
	// ****************************************
	// A running average rather than the last sample keeps a final wobble out of holdover.
	logic [23:0] history;
	logic signed [24:0] hist_diff;
	logic signed [24:0] hist_step;
	assign hist_diff = $signed({1'b0, loop_freq}) - $signed({1'b0, history});
	assign hist_step = hist_diff >>> history_shift;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			history <= 24'h000000;
		end else if (clock_enable && state == st_normal && next_valid) begin
			history <= history + hist_step[23:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			holdover_freq <= 24'h000000;
		end else if (clock_enable && state != st_holdover) begin
			holdover_freq <= history;
		end
	end

	// ****************************************
	// Loop settings
	// ****************************************
	bw_sel_t bw_sel;
	bw_eff_t next_bw;
	logic ref_2k;
	logic ref_8k;
	assign bw_sel = bw_sel_t'(loop_control_primary[bandwidth_lsb +: 2]);
	assign ref_2k = ref_is_2k[active_ref[1] ? 2 : {1'b0, active_ref[0]}];
	assign ref_8k = ref_is_8k[active_ref[1] ? 2 : {1'b0, active_ref[0]}];

	always_comb begin
		unique case (bw_sel)
			bw_sel_0p1: next_bw = bw_0p1_hz;
			bw_sel_14: next_bw = bw_14_hz;
			bw_sel_28: next_bw = ref_2k ? bw_14_hz : bw_28_hz;
			bw_sel_wide: begin
				if (ref_2k) begin
					next_bw = bw_14_hz;
				end else if (ref_8k) begin
					next_bw = bw_56_hz;
				end else begin
					next_bw = bw_890_hz;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			loop_cfg <= '{bandwidth: bw_0p1_hz, phase_slope_limit: psl_885_ns, hitless: 1'b1};
		end else if (clock_enable) begin
			loop_cfg.bandwidth <= next_bw;
			loop_cfg.phase_slope_limit <= phase_slope_limit_t'(
				loop_control_primary[slope_limit_lsb +: 2]);
			loop_cfg.hitless <= loop_control_primary[hitless_bit];
		end
	end

	// ****************************************
	// Status, pins and interrupt
	// ****************************************
	status_t next_status;
	assign next_status = '{ever_synced: ever_synced, active_ref: active_ref, state: state};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status <= '{ever_synced: 1'b0, active_ref: 2'd0, state: st_free_run};
			lock_pin <= 1'b0;
			holdover_pin <= 1'b0;
		end else if (clock_enable) begin
			status <= next_status;
			lock_pin <= state == st_normal;
			holdover_pin <= state == st_holdover;
		end
	end

	logic status_read;
	assign status_read = reg_read && reg_addr == device_status_addr;

	// A change in the same cycle as the clearing read wins, so no event is lost.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_pending <= 1'b0;
		end else if (clock_enable) begin
			if (status != next_status) begin
				status_pending <= 1'b1;
			end else if (status_read) begin
				status_pending <= 1'b0;
			end
		end
	end

	assign irq_n = !status_pending;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (clock_enable && reg_read) begin
			unique case (reg_addr)
				hardware_pin_control_addr: reg_rdata <= hardware_pin_control;
				device_status_addr: reg_rdata <= {3'h0, status};
				loop_control_primary_addr: reg_rdata <= loop_control_primary;
				loop_control_secondary_addr: reg_rdata <= loop_control_secondary;
				operating_mode_select_addr: reg_rdata <= operating_mode_select;
				manual_reference_select_addr: reg_rdata <= manual_reference_select;
				reference_priority_low_addr: reg_rdata <= reference_priority_low;
				reference_priority_high_addr: reg_rdata <= reference_priority_high;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

/* File: testbench/dpll_mode_monitor.sv */
// Checker of state, pin and interrupt behaviour at the controller ports.
`timescale 1ns/1ps
module dpll_mode_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] ref_qualified,
	input wire logic [2:0] ref_is_2k,
	input wire logic acquisition_done,
	input wire dpll_mode_pkg::status_t status,
	input wire dpll_mode_pkg::loop_cfg_t loop_cfg,
	input wire logic [23:0] holdover_freq,
	input wire logic lock_pin,
	input wire logic holdover_pin,
	input wire logic irq_n
);
	import dpll_mode_pkg::*;
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// The pins are registered on the same edge as the status; they are judged only on a steady state.
	lock_pin_level_a: assert property (
		$stable(status.state) |-> lock_pin == (status.state == st_normal))
		else $error("lock pin disagrees with state");
	holdover_pin_level_a: assert property (
		$stable(status.state) |-> holdover_pin == (status.state == st_holdover))
		else $error("holdover pin disagrees with state");
	status_irq_a: assert property ($changed(status) |-> ##[0:2] !irq_n)
		else $error("no interrupt after status change");
	holdover_freeze_a: assert property (
		status.state == st_holdover && $past(status.state) == st_holdover |->
		$stable(holdover_freq))
		else $error("holdover frequency moved");
	no_direct_lock_a: assert property (
		status.state == st_free_run |=> status.state != st_normal)
		else $error("free-run jumped to normal");
	normal_synced_a: assert property (
		status.state == st_normal && $past(status.state) == st_normal |-> status.ever_synced)
		else $error("normal without sync flag");
	holdover_synced_a: assert property (
		status.state == st_holdover |-> status.ever_synced)
		else $error("holdover before any sync");
	acquire_needs_ref_a: assert property (
		$past(status.state) == st_free_run && status.state == st_acquiring |->
		$past(ref_qualified) != 3'h0 || $past(ref_qualified, 2) != 3'h0)
		else $error("acquisition with no qualified reference");
	lock_needs_done_a: assert property (
		$past(status.state) == st_acquiring && status.state == st_normal |->
		$past(acquisition_done) || $past(acquisition_done, 2))
		else $error("normal entered without acquisition done");
	narrow_band_2k_a: assert property (
		(ref_is_2k == 3'h7) [*3] |-> loop_cfg.bandwidth inside {bw_0p1_hz, bw_14_hz})
		else $error("wide bandwidth on 2 kHz reference");
endmodule
bind dpll_mode_controller dpll_mode_monitor i_dpll_mode_monitor (.clock(clock), .rst(rst),
	.ref_qualified(ref_qualified), .ref_is_2k(ref_is_2k), .acquisition_done(acquisition_done),
	.status(status), .loop_cfg(loop_cfg), .holdover_freq(holdover_freq), .lock_pin(lock_pin),
	.holdover_pin(holdover_pin), .irq_n(irq_n));

/* File: testbench/host_model.sv */
// Host side of the internal register port, issuing single byte accesses.
`timescale 1ns/1ps
module host_model (
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic [6:0] reg_addr,
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_wdata
);
	// ****************************************
	// Register accesses
	// ****************************************
	initial begin
		reg_addr = 7'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		// Stale data is inverted so a late capture cannot pass by luck.
		reg_wdata <= ~v;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the loop mode controller.
`timescale 1ns/1ps
module tb_top;
	import dpll_mode_pkg::*;
	// ****************************************
	// Stimulus and checking
	// ****************************************
	typedef struct packed {
		logic [7:0] wdata;
		logic [2:0] is_2k;
		logic [2:0] is_8k;
		loop_cfg_t cfg;
	} row_t;
	logic clock, rst, clock_enable, mode_pin, acquisition_done, lock_pin, holdover_pin, irq_n;
	logic [2:0] ref_qualified, ref_is_2k, ref_is_8k;
	logic [23:0] loop_freq = 24'h000000;
	logic [23:0] holdover_freq, hf;
	logic [6:0] reg_addr;
	logic reg_write, reg_read;
	logic [7:0] reg_wdata, reg_rdata, d;
	status_t status;
	loop_cfg_t loop_cfg;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// All references share one class so the result does not hang on the active one.
	row_t rows [8] = '{
		'{8'h00, 3'h0, 3'h0, {bw_0p1_hz, psl_885_ns, 1'b0}},
		'{8'h05, 3'h0, 3'h0, {bw_14_hz, psl_7p5_us, 1'b0}},
		'{8'h1a, 3'h0, 3'h0, {bw_28_hz, psl_61_us, 1'b1}},
		'{8'h0f, 3'h0, 3'h0, {bw_890_hz, psl_unlimited, 1'b0}},
		'{8'h03, 3'h0, 3'h7, {bw_56_hz, psl_885_ns, 1'b0}},
		'{8'h03, 3'h7, 3'h0, {bw_14_hz, psl_885_ns, 1'b0}},
		'{8'h12, 3'h7, 3'h0, {bw_14_hz, psl_885_ns, 1'b1}},
		'{8'h01, 3'h7, 3'h0, {bw_14_hz, psl_885_ns, 1'b0}}
	};
	dpll_mode_controller i_dpll_mode_controller (.clock(clock), .rst(rst),
		.clock_enable(clock_enable), .mode_pin(mode_pin), .ref_qualified(ref_qualified),
		.ref_is_2k(ref_is_2k),
		.ref_is_8k(ref_is_8k), .acquisition_done(acquisition_done), .loop_freq(loop_freq),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .status(status), .loop_cfg(loop_cfg),
		.holdover_freq(holdover_freq), .lock_pin(lock_pin), .holdover_pin(holdover_pin),
		.irq_n(irq_n));
	host_model i_host_model (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));
	task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
		total_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %0t %s: saw %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic wait_state(input dpll_state_t want, input string what);
		#1;
		for (int n = 0; n < 20 && status.state !== want; n++) begin
			@(posedge clock);
			#1;
		end
		check(status.state, want, what);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		loop_freq <= loop_freq + 24'h000010;
		if (cycles == 3000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		rst = 1'b1;
		clock_enable = 1'b1;
		mode_pin = 1'b1;
		acquisition_done = 1'b0;
		ref_qualified = 3'h0;
		ref_is_2k = 3'h0;
		ref_is_8k = 3'h0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		check(status, 5'h00, "status after reset");
		check(loop_cfg, {bw_0p1_hz, psl_885_ns, 1'b1}, "settings after reset");
		check({lock_pin, holdover_pin, irq_n}, 3'b001, "pins after reset");
		i_host_model.rd(operating_mode_select_addr, d);
		check(d, 8'h01, "strap high");
		i_host_model.rd(hardware_pin_control_addr, d);
		check(d, 8'h00, "pin control reset");
		i_host_model.rd(7'h7f, d);
		check(d, 8'h00, "unmapped read");
		@(posedge clock);
		ref_qualified <= 3'h1;
		acquisition_done <= 1'b1;
		repeat (10) @(posedge clock);
		#1 check(status.state, st_free_run, "manual free-run holds");
		foreach (rows[i]) begin
			@(posedge clock);
			ref_is_2k <= rows[i].is_2k;
			ref_is_8k <= rows[i].is_8k;
			i_host_model.wr(loop_control_primary_addr, rows[i].wdata);
			i_host_model.rd(loop_control_primary_addr, d);
			check(d, rows[i].wdata, "loop control readback");
			check(loop_cfg, rows[i].cfg, "loop settings");
		end
		// A write made while the enable is low must be lost, leaving the strapped mode.
		@(posedge clock);
		clock_enable <= 1'b0;
		i_host_model.wr(operating_mode_select_addr, 8'h02);
		clock_enable <= 1'b1;
		i_host_model.rd(operating_mode_select_addr, d);
		check(d, 8'h01, "write frozen by enable");
		@(posedge clock);
		acquisition_done <= 1'b0;
		i_host_model.wr(operating_mode_select_addr, 8'h02);
		wait_state(st_acquiring, "acquiring");
		@(posedge clock);
		acquisition_done <= 1'b1;
		wait_state(st_normal, "locked");
		repeat (2) @(posedge clock);
		#1 check({lock_pin, holdover_pin, irq_n}, 3'b100, "pins when locked");
		i_host_model.rd(device_status_addr, d);
		check(d, {3'b001, 2'b00, st_normal}, "status byte");
		check(irq_n, 1'b1, "interrupt cleared by read");
		@(posedge clock);
		ref_qualified <= 3'h0;
		wait_state(st_holdover, "holdover");
		repeat (2) @(posedge clock);
		#1 hf = holdover_freq;
		repeat (6) @(posedge clock);
		#1 check(holdover_freq, hf, "history frozen");
		check(hf == 24'h000000, 1'b0, "history captured");
		check({lock_pin, holdover_pin}, 2'b01, "pins in holdover");
		@(posedge clock);
		ref_qualified <= 3'h3;
		mode_pin <= 1'b0;
		i_host_model.wr(manual_reference_select_addr, 8'h01);
		i_host_model.wr(hardware_pin_control_addr, 8'h01);
		// The automatic mode has already locked to the first reference here.
		wait_state(st_acquiring, "pin manual reacquire");
		wait_state(st_normal, "pin manual normal");
		check(status.active_ref, 2'h1, "register chosen ref");
		@(posedge clock);
		ref_qualified <= 3'h1;
		wait_state(st_holdover, "manual ref lost");
		i_host_model.wr(hardware_pin_control_addr, 8'h00);
		wait_state(st_normal, "software auto");
		check(status.active_ref, 2'h0, "auto picks valid ref");
		@(posedge clock);
		rst <= 1'b1;
		mode_pin <= 1'b0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 check(status, 5'h00, "status after second reset");
		i_host_model.rd(operating_mode_select_addr, d);
		check(d, 8'h00, "strap low");
		wait_state(st_normal, "strap manual normal");
		conclude();
	end
endmodule
